// >>> hdl/aosr_pkg.sv
package aosr_pkg;

	// ==========================================================
	// Widths
	// ==========================================================
	localparam int AOSR_REG_W    = 16;
	localparam int AOSR_ALARM_N  = 4;
	localparam int AOSR_QDEPTH   = 16;

	// ==========================================================
	// Alarm register bit positions
	// ==========================================================
	localparam int ALM_QNE_BIT   = 4;
	localparam int ALM_NUM_LSB   = 6;
	localparam int ALM_LOW_BIT   = 12;
	localparam int ALM_UP_BIT    = 13;

	// ==========================================================
	// Operation condition bit positions
	// ==========================================================
	localparam int OPR_CAL_BIT   = 0;
	localparam int OPR_TEST_BIT  = 1;
	localparam int OPR_SCAN_BIT  = 4;
	localparam int OPR_TRIG_BIT  = 5;
	localparam int OPR_EXT_BIT   = 7;
	localparam int OPR_CFG_BIT   = 8;
	localparam int OPR_LOCK_BIT  = 10;
	localparam int OPR_ERR_BIT   = 13;
	localparam int OPR_BUSY_BIT  = 14;

	// ==========================================================
	// Values after reset and after preset
	// ==========================================================
	localparam logic [15:0] ENA_RST_VAL    = 16'h0000;
	localparam logic [15:0] ENA_PRESET_VAL = 16'h0000;
	localparam logic [15:0] REG_ZERO       = 16'h0000;
	localparam logic        CFG_CHG_RST    = 1'b0;

	// ==========================================================
	// Decoded host commands
	// ==========================================================
	typedef enum logic [3:0] {
		AOSR_NOP          = 4'h0,
		AOSR_RD_ALM_COND  = 4'h1,
		AOSR_WR_ALM_ENA   = 4'h2,
		AOSR_RD_ALM_ENA   = 4'h3,
		AOSR_RD_ALM_EVT   = 4'h4,
		AOSR_RD_OPR_COND  = 4'h5,
		AOSR_WR_OPR_ENA   = 4'h6,
		AOSR_RD_OPR_ENA   = 4'h7,
		AOSR_WR_QUE_ENA   = 4'h8,
		AOSR_RD_QUE_ENA   = 4'h9,
		AOSR_CLEAR_STATUS = 4'hA,
		AOSR_PRESET       = 4'hB,
		AOSR_FACTORY_RST  = 4'hC
	} aosr_op_t;

	typedef struct packed {
		logic        valid;
		aosr_op_t    op;
		logic [15:0] value;
	} aosr_cmd_t;

	typedef struct packed {
		logic        valid;
		logic        err;
		logic [15:0] value;
	} aosr_rsp_t;

	typedef struct packed {
		logic [3:0] numbered;
		logic       lower_limit;
		logic       upper_limit;
	} aosr_alarm_t;

	typedef struct packed {
		logic calibrating;
		logic self_test;
		logic scanning;
		logic awaiting_trigger_flag;
		logic ext_storage_present_flag;
		logic locked;
		logic error_queue_nonempty;
		logic busy;
	} aosr_oper_t;

endpackage

// >>> hdl/aosr_alarm_queue.sv
module aosr_alarm_queue
	import aosr_pkg::*;
#(
	parameter int DEPTH = AOSR_QDEPTH
) (
	input  wire logic clk_in,
	input  wire logic sys_rst_in,
	input  wire logic push_in,
	input  wire logic pop_in,
	input  wire logic flush_in,
	output logic      not_empty_out,
	output logic      full_out
);

	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [CW-1:0] ONE_CNT  = CW'(1);
	localparam logic [CW-1:0] ZERO_CNT = CW'(0);

	if (DEPTH < 1) begin : g_chk_depth
		$error("aosr_alarm_queue: DEPTH must be at least 1");
	end

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          inc;
	logic          dec;

	// ==========================================================
	// Occupancy count
	// ==========================================================
	always_comb begin
		inc   = push_in && (cnt_q != FULL_CNT);
		dec   = pop_in && (cnt_q != ZERO_CNT);
		cnt_d = cnt_q;
		// A push in the flush cycle survives the flush
		if (flush_in) begin
			cnt_d = push_in ? ONE_CNT : ZERO_CNT;
		end else if (inc && !dec) begin
			cnt_d = cnt_q + ONE_CNT;
		end else if (dec && !inc) begin
			cnt_d = cnt_q - ONE_CNT;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt_q <= ZERO_CNT;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign not_empty_out = (cnt_q != ZERO_CNT);
	assign full_out      = (cnt_q == FULL_CNT);

endmodule

// >>> hdl/aosr_event_latch.sv
module aosr_event_latch
	import aosr_pkg::*;
#(
	parameter int WIDTH = AOSR_REG_W
) (
	input  wire logic             clk_in,
	input  wire logic             sys_rst_in,
	input  wire logic [WIDTH-1:0] cond_in,
	input  wire logic             clear_in,
	output logic      [WIDTH-1:0] event_out
);

	if (WIDTH < 1) begin : g_chk_width
		$error("aosr_event_latch: WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] prev_q;
	logic [WIDTH-1:0] prev_d;
	logic [WIDTH-1:0] evt_q;
	logic [WIDTH-1:0] evt_d;

	// ==========================================================
	// Rising edge capture, sticky until cleared
	// ==========================================================
	always_comb begin
		prev_d = cond_in;
		// New edge wins over a clear in the same cycle
		evt_d  = (evt_q & ~{WIDTH{clear_in}}) | (cond_in & ~prev_q);
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			prev_q <= '0;
			evt_q  <= '0;
		end else begin
			prev_q <= prev_d;
			evt_q  <= evt_d;
		end
	end

	assign event_out = evt_q;

endmodule

// >>> hdl/aosr_status_regs.sv
// Overview of operation
// - Alarm condition register is read-only; reading changes no bit.
// - Clear-status empties the alarm queue and drops the queue-not-empty bit 4, unless an alarm push comes in the same cycle.
// - Alarm bit 4 is high while the alarm queue holds an entry, following the queue occupancy one cycle later.
// - Numbered alarms one to four appear on alarm bits 6 through 9.
// - Lower-limit alarm sets bit 12, upper-limit alarm sets bit 13.
// - Alarm enable mask holds any written 16-bit value and reads it back.
// - An alarm event reaches the summary only where its enable bit is one.
// - Status preset loads zero into the alarm enable mask.
// - Alarm event bits stay set until an event read or clear-status.
// - Every status read answers the register value as an unsigned integer.
// - Operation condition register is read-only; reading clears nothing.
// - Operation bit 14 is high while a long-running command executes.
// - Factory reset sets operation bit 8, scan configuration changed.
// - Calibrating bit 0, self-test bit 1, scanning bit 4, awaiting trigger bit 5.
// - External storage bit 7, locked bit 10, error queue not empty bit 13.
// - Status preset also zeroes the operation and questionable enable masks.
module aosr_status_regs
	import aosr_pkg::*;
#(
	parameter int QUEUE_DEPTH = AOSR_QDEPTH
) (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire aosr_cmd_t   cmd_in,
	input  wire aosr_alarm_t alarm_in,
	input  wire logic        alarm_push_in,
	input  wire logic        alarm_pop_in,
	input  wire aosr_oper_t  oper_in,
	input  wire logic        scan_cfg_changed_in,
	input  wire logic        scan_cfg_ack_in,
	output aosr_rsp_t        rsp_out,
	output logic             alarm_summary_out,
	output logic [15:0]      alarm_cond_out,
	output logic [15:0]      alarm_event_out,
	output logic [15:0]      alarm_enable_out,
	output logic [15:0]      oper_cond_out,
	output logic [15:0]      oper_enable_out,
	output logic [15:0]      ques_enable_out,
	output logic             alarm_queue_full_out
);

	// ==========================================================
	// Elaboration checks
	// ==========================================================
	if (QUEUE_DEPTH < 1) begin : g_chk_depth
		$error("aosr_status_regs: QUEUE_DEPTH must be at least 1");
	end

	// The ports and the bit maps assume one 16-bit word per register
	if (AOSR_REG_W != 16) begin : g_chk_width
		$error("aosr_status_regs: register width must be 16");
	end

	if (AOSR_ALARM_N != 4) begin : g_chk_alarm_cnt
		$error("aosr_status_regs: the alarm input carries four numbered alarms");
	end

	if (ALM_NUM_LSB <= ALM_QNE_BIT || ALM_NUM_LSB + AOSR_ALARM_N > ALM_LOW_BIT) begin : g_chk_alarm_num
		$error("aosr_status_regs: numbered alarm field overlaps another alarm bit");
	end

	if (ALM_UP_BIT <= ALM_LOW_BIT || ALM_UP_BIT >= AOSR_REG_W) begin : g_chk_alarm_lim
		$error("aosr_status_regs: limit alarm bits out of order or out of the word");
	end

	if (OPR_BUSY_BIT >= AOSR_REG_W) begin : g_chk_oper
		$error("aosr_status_regs: operation busy bit outside the word");
	end

	// ==========================================================
	// Command decode
	// ==========================================================
	logic is_cls;
	logic is_preset;
	logic is_rst;
	logic rd_evt;
	logic wr_alm_ena;
	logic wr_opr_ena;
	logic wr_que_ena;

	always_comb begin
		is_cls     = cmd_in.valid && (cmd_in.op == AOSR_CLEAR_STATUS);
		is_preset  = cmd_in.valid && (cmd_in.op == AOSR_PRESET);
		is_rst     = cmd_in.valid && (cmd_in.op == AOSR_FACTORY_RST);
		rd_evt     = cmd_in.valid && (cmd_in.op == AOSR_RD_ALM_EVT);
		wr_alm_ena = cmd_in.valid && (cmd_in.op == AOSR_WR_ALM_ENA);
		wr_opr_ena = cmd_in.valid && (cmd_in.op == AOSR_WR_OPR_ENA);
		wr_que_ena = cmd_in.valid && (cmd_in.op == AOSR_WR_QUE_ENA);
	end

	// ==========================================================
	// Alarm queue occupancy
	// ==========================================================
	logic queue_not_empty;
	logic queue_full;

	// Only occupancy is kept here; the queued alarm records live elsewhere
	aosr_alarm_queue #(
		.DEPTH (QUEUE_DEPTH)
	) u_queue (
		.clk_in        (clk_in),
		.sys_rst_in    (sys_rst_in),
		.push_in       (alarm_push_in),
		.pop_in        (alarm_pop_in),
		.flush_in      (is_cls),
		.not_empty_out (queue_not_empty),
		.full_out      (queue_full)
	);

	// ==========================================================
	// Alarm condition register
	// ==========================================================
	logic [15:0] alm_cond_q;
	logic [15:0] alm_cond_d;

	// Bits not assigned below stay zero
	always_comb begin
		alm_cond_d = REG_ZERO;
		alm_cond_d[ALM_QNE_BIT] = queue_not_empty;
		alm_cond_d[ALM_NUM_LSB +: AOSR_ALARM_N] = alarm_in.numbered;
		alm_cond_d[ALM_LOW_BIT] = alarm_in.lower_limit;
		alm_cond_d[ALM_UP_BIT]  = alarm_in.upper_limit;
	end

	// Source-driven except bit 4, which clear-status drops by flushing the queue
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			alm_cond_q <= REG_ZERO;
		end else begin
			alm_cond_q <= alm_cond_d;
		end
	end

	// ==========================================================
	// Alarm event latch
	// ==========================================================
	// Events include bit 4, so a newly filled queue also reaches the summary
	logic [15:0] alm_evt;
	logic        evt_clear;

	// Read-to-clear and clear-status share one clear
	assign evt_clear = rd_evt || is_cls;

	aosr_event_latch #(
		.WIDTH (AOSR_REG_W)
	) u_alarm_evt (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.cond_in    (alm_cond_q),
		.clear_in   (evt_clear),
		.event_out  (alm_evt)
	);

	// ==========================================================
	// Enable masks
	// ==========================================================
	logic [15:0] alm_ena_q;
	logic [15:0] alm_ena_d;
	logic [15:0] opr_ena_q;
	logic [15:0] opr_ena_d;
	logic [15:0] que_ena_q;
	logic [15:0] que_ena_d;

	// Factory reset leaves the masks alone; only preset clears them
	// Preset wins if a write and a preset ever coincide
	always_comb begin
		alm_ena_d = alm_ena_q;
		opr_ena_d = opr_ena_q;
		que_ena_d = que_ena_q;
		if (is_preset) begin
			alm_ena_d = ENA_PRESET_VAL;
			opr_ena_d = ENA_PRESET_VAL;
			que_ena_d = ENA_PRESET_VAL;
		end else begin
			if (wr_alm_ena) begin
				alm_ena_d = cmd_in.value;
			end
			if (wr_opr_ena) begin
				opr_ena_d = cmd_in.value;
			end
			if (wr_que_ena) begin
				que_ena_d = cmd_in.value;
			end
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			alm_ena_q <= ENA_RST_VAL;
			opr_ena_q <= ENA_RST_VAL;
			que_ena_q <= ENA_RST_VAL;
		end else begin
			alm_ena_q <= alm_ena_d;
			opr_ena_q <= opr_ena_d;
			que_ena_q <= que_ena_d;
		end
	end

	// ==========================================================
	// Operation condition register
	// ==========================================================
	logic        cfg_chg_q;
	logic        cfg_chg_d;
	logic [15:0] opr_cond_q;
	logic [15:0] opr_cond_d;

	// A setting cause beats the acknowledge in the same cycle
	always_comb begin
		cfg_chg_d = cfg_chg_q;
		if (is_rst || scan_cfg_changed_in) begin
			cfg_chg_d = 1'b1;
		end else if (scan_cfg_ack_in) begin
			cfg_chg_d = 1'b0;
		end
	end

	// Bit 8 takes the next flag value so it shows one cycle after its cause
	always_comb begin
		opr_cond_d = REG_ZERO;
		opr_cond_d[OPR_CAL_BIT]  = oper_in.calibrating;
		opr_cond_d[OPR_TEST_BIT] = oper_in.self_test;
		opr_cond_d[OPR_SCAN_BIT] = oper_in.scanning;
		opr_cond_d[OPR_TRIG_BIT] = oper_in.awaiting_trigger_flag;
		opr_cond_d[OPR_EXT_BIT]  = oper_in.ext_storage_present_flag;
		opr_cond_d[OPR_CFG_BIT]  = cfg_chg_d;
		opr_cond_d[OPR_LOCK_BIT] = oper_in.locked;
		opr_cond_d[OPR_ERR_BIT]  = oper_in.error_queue_nonempty;
		opr_cond_d[OPR_BUSY_BIT] = oper_in.busy;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cfg_chg_q <= CFG_CHG_RST;
		end else begin
			cfg_chg_q <= cfg_chg_d;
		end
	end

	// Reads never feed back here
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			opr_cond_q <= REG_ZERO;
		end else begin
			opr_cond_q <= opr_cond_d;
		end
	end

	// ==========================================================
	// Query answers
	// ==========================================================
	// Answers stand one cycle; nothing stalls, so the host must take them then
	aosr_rsp_t rsp_q;
	aosr_rsp_t rsp_d;

	// Value is the plain binary word: its integer is the weighted bit sum
	always_comb begin
		rsp_d       = '0;
		rsp_d.valid = cmd_in.valid;
		unique case (cmd_in.op)
			AOSR_RD_ALM_COND: rsp_d.value = alm_cond_q;
			AOSR_RD_ALM_ENA:  rsp_d.value = alm_ena_q;
			AOSR_RD_ALM_EVT:  rsp_d.value = alm_evt;
			AOSR_RD_OPR_COND: rsp_d.value = opr_cond_q;
			AOSR_RD_OPR_ENA:  rsp_d.value = opr_ena_q;
			AOSR_RD_QUE_ENA:  rsp_d.value = que_ena_q;
			AOSR_NOP:         rsp_d.valid = 1'b0;
			AOSR_WR_ALM_ENA,
			AOSR_WR_OPR_ENA,
			AOSR_WR_QUE_ENA,
			AOSR_CLEAR_STATUS,
			AOSR_PRESET,
			AOSR_FACTORY_RST: rsp_d.value = REG_ZERO;
			// Undefined codes answer with an error flag
			default:          rsp_d.err   = cmd_in.valid;
		endcase
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rsp_q <= '0;
		end else begin
			rsp_q <= rsp_d;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	// Summary is a gate on flop outputs, one level deep
	assign alarm_summary_out    = |(alm_evt & alm_ena_q);
	assign rsp_out              = rsp_q;
	assign alarm_cond_out       = alm_cond_q;
	assign alarm_event_out      = alm_evt;
	assign alarm_enable_out     = alm_ena_q;
	assign oper_cond_out        = opr_cond_q;
	assign oper_enable_out      = opr_ena_q;
	assign ques_enable_out      = que_ena_q;
	assign alarm_queue_full_out = queue_full;

endmodule

// >>> testbench/aosr_status_regs_props.sv
module aosr_status_regs_props
	import aosr_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        sys_rst_in,
	input wire aosr_cmd_t   cmd_in,
	input wire aosr_alarm_t alarm_in,
	input wire logic        alarm_push_in,
	input wire aosr_oper_t  oper_in,
	input wire aosr_rsp_t   rsp_out,
	input wire logic        alarm_summary_out,
	input wire logic [15:0] alarm_cond_out,
	input wire logic [15:0] alarm_event_out,
	input wire logic [15:0] alarm_enable_out,
	input wire logic [15:0] oper_cond_out,
	input wire logic [15:0] oper_enable_out,
	input wire logic [15:0] ques_enable_out,
	input wire logic        alarm_queue_full_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Rising condition bits, kept here so no nested past is needed
	// ==========================================================
	logic [15:0] prev_cond_q;
	logic [15:0] rise;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			prev_cond_q <= 16'h0000;
		end else begin
			prev_cond_q <= alarm_cond_out;
		end
	end
	assign rise = alarm_cond_out & ~prev_cond_q;

	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	// ==========================================================
	// Assertions
	// ==========================================================
	a_unused_zero: assert property ((alarm_cond_out & 16'hCC2F) == 16'h0000 &&
		(alarm_event_out & 16'hCC2F) == 16'h0000 && (oper_cond_out & 16'h9A4C) == 16'h0000)
		else $error("unused status bit set");
	a_alarm_map: assert property (!$past(sys_rst_in) |-> alarm_cond_out[13:6] ==
		{$past(alarm_in.upper_limit), $past(alarm_in.lower_limit), 2'b00, $past(alarm_in.numbered)})
		else $error("alarm condition bits do not follow alarm inputs");
	a_busy_follow: assert property (!$past(sys_rst_in) |-> oper_cond_out[14] == $past(oper_in.busy))
		else $error("busy bit does not follow busy input");
	a_rsp_every: assert property (cmd_in.valid && cmd_in.op != AOSR_NOP |=> rsp_out.valid)
		else $error("command not answered next cycle");
	a_rsp_quiet: assert property (!cmd_in.valid |=> !rsp_out.valid)
		else $error("answer without command");
	a_cond_read: assert property (cmd_in.valid && cmd_in.op == AOSR_RD_ALM_COND |=>
		rsp_out.value == $past(alarm_cond_out))
		else $error("alarm condition read value wrong");
	a_oper_read: assert property (cmd_in.valid && cmd_in.op == AOSR_RD_OPR_COND |=>
		rsp_out.value == $past(oper_cond_out))
		else $error("operation condition read value wrong");
	a_enable_write: assert property (cmd_in.valid && cmd_in.op == AOSR_WR_ALM_ENA |=>
		alarm_enable_out == $past(cmd_in.value))
		else $error("alarm enable not loaded");
	a_preset_zero: assert property (cmd_in.valid && cmd_in.op == AOSR_PRESET |=>
		alarm_enable_out == 16'h0000 && oper_enable_out == 16'h0000 && ques_enable_out == 16'h0000)
		else $error("preset left an enable mask set");
	a_event_hold: assert property (!(cmd_in.valid && (cmd_in.op == AOSR_RD_ALM_EVT ||
		cmd_in.op == AOSR_CLEAR_STATUS)) |=> (alarm_event_out & $past(alarm_event_out)) == $past(alarm_event_out))
		else $error("alarm event bit dropped without clear");
	a_event_rise: assert property (rise != 16'h0000 |=> (alarm_event_out & $past(rise)) == $past(rise))
		else $error("rising condition did not latch an event");
	a_summary_mask: assert property (alarm_summary_out == |(alarm_event_out & alarm_enable_out))
		else $error("summary does not match masked events");
	a_cls_flush: assert property (cmd_in.valid && cmd_in.op == AOSR_CLEAR_STATUS && !alarm_push_in |=>
		##1 !alarm_cond_out[4])
		else $error("queue bit still set after clear status");
	a_qne_push: assert property (alarm_push_in |=> ##1 alarm_cond_out[4])
		else $error("queue bit low after push");
	a_cfg_rst: assert property (cmd_in.valid && cmd_in.op == AOSR_FACTORY_RST |=> oper_cond_out[8])
		else $error("factory reset did not flag configuration change");

	c_event_read: cover property (cmd_in.valid && cmd_in.op == AOSR_RD_ALM_EVT && alarm_event_out != 16'h0000);
	c_queue_full: cover property (alarm_queue_full_out);
	c_summary: cover property (alarm_summary_out);
endmodule

bind aosr_status_regs aosr_status_regs_props i_props (
	.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_in(cmd_in), .alarm_in(alarm_in),
	.alarm_push_in(alarm_push_in), .oper_in(oper_in), .rsp_out(rsp_out),
	.alarm_summary_out(alarm_summary_out), .alarm_cond_out(alarm_cond_out),
	.alarm_event_out(alarm_event_out), .alarm_enable_out(alarm_enable_out),
	.oper_cond_out(oper_cond_out), .oper_enable_out(oper_enable_out),
	.ques_enable_out(ques_enable_out), .alarm_queue_full_out(alarm_queue_full_out)
);

// >>> testbench/aosr_host_model.sv
module aosr_host_model
	import aosr_pkg::*;
(
	input  wire logic      clk_in,
	output aosr_cmd_t      cmd_out,
	input  wire aosr_rsp_t rsp_in
);
	timeunit 1ns;
	timeprecision 1ps;

	initial cmd_out = '0;

	// ==========================================================
	// One command, held for exactly one taking edge
	// ==========================================================
	task automatic xfer(input aosr_op_t op, input logic [15:0] v, output logic [15:0] val);
		@(negedge clk_in);
		cmd_out = '{valid: 1'b1, op: op, value: v};
		@(negedge clk_in);
		// The answer stands only in the cycle after the taking edge
		// A missing or refused answer reads as unknown so no compare can pass
		val = (rsp_in.valid === 1'b1 && rsp_in.err === 1'b0) ? rsp_in.value : 'x;
		cmd_out = '{valid: 1'b0, op: AOSR_NOP, value: ~v};
	endtask
endmodule

// >>> testbench/aosr_status_regs_tb.sv
module aosr_status_regs_tb
	import aosr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_in;
	logic        sys_rst_in;
	aosr_cmd_t   cmd;
	aosr_alarm_t alarm;
	logic        push;
	logic        pop;
	aosr_oper_t  oper;
	logic        cfg_chg;
	logic        cfg_ack;
	aosr_rsp_t   rsp;
	logic        summary;
	logic        full;
	logic [15:0] val;
	int          n_mismatch;
	int          compares;

	aosr_status_regs #(.QUEUE_DEPTH(2)) i_aosr_status_regs (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cmd_in(cmd), .alarm_in(alarm),
		.alarm_push_in(push), .alarm_pop_in(pop), .oper_in(oper), .scan_cfg_changed_in(cfg_chg),
		.scan_cfg_ack_in(cfg_ack), .rsp_out(rsp), .alarm_summary_out(summary), .alarm_cond_out(),
		.alarm_event_out(), .alarm_enable_out(), .oper_cond_out(), .oper_enable_out(),
		.ques_enable_out(), .alarm_queue_full_out(full)
	);
	aosr_host_model i_aosr_host_model (.clk_in(clk_in), .cmd_out(cmd), .rsp_in(rsp));

	// ==========================================================
	// Common tasks
	// ==========================================================
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			n_mismatch++;
		end
	endtask

	task automatic rd(input aosr_op_t op, input string nm, input logic [15:0] exp);
		i_aosr_host_model.xfer(op, 16'h0000, val);
		chk(nm, exp, val);
	endtask

	task automatic wr(input aosr_op_t op, input logic [15:0] v);
		i_aosr_host_model.xfer(op, v, val);
		chk("write answer", 16'h0000, val);
	endtask

	task automatic ticks(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	task automatic wrap_up();
		if (n_mismatch == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	// ==========================================================
	task automatic t_alarm_bits();
		@(negedge clk_in);
		alarm = '{numbered: 4'hA, lower_limit: 1'b1, upper_limit: 1'b0};
		ticks(3);
		rd(AOSR_RD_ALM_COND, "alarm cond", 16'h1280);
		rd(AOSR_RD_ALM_COND, "alarm cond again", 16'h1280);
		rd(AOSR_RD_ALM_EVT, "alarm event", 16'h1280);
		rd(AOSR_RD_ALM_EVT, "alarm event cleared", 16'h0000);
		alarm = '{numbered: 4'h5, lower_limit: 1'b0, upper_limit: 1'b1};
		ticks(3);
		rd(AOSR_RD_ALM_COND, "alarm cond upper", 16'h2140);
		alarm = '0;
		ticks(3);
		wr(AOSR_CLEAR_STATUS, 16'h0000);
		rd(AOSR_RD_ALM_EVT, "event after clear", 16'h0000);
	endtask

	task automatic t_queue();
		repeat (3) begin
			@(negedge clk_in);
			push = 1'b1;
			@(negedge clk_in);
			push = 1'b0;
		end
		ticks(2);
		chk("queue full", 16'h0001, {15'h0000, full});
		rd(AOSR_RD_ALM_COND, "queue not empty", 16'h0010);
		pop = 1'b1;
		@(negedge clk_in);
		pop = 1'b0;
		ticks(2);
		chk("queue not full", 16'h0000, {15'h0000, full});
		wr(AOSR_CLEAR_STATUS, 16'h0000);
		ticks(1);
		rd(AOSR_RD_ALM_COND, "queue flushed", 16'h0000);
	endtask

	task automatic t_enable();
		wr(AOSR_WR_ALM_ENA, 16'hFFFF);
		rd(AOSR_RD_ALM_ENA, "alarm enable max", 16'hFFFF);
		wr(AOSR_WR_ALM_ENA, 16'hFFBF);
		@(negedge clk_in);
		alarm.numbered = 4'h1;
		ticks(3);
		chk("summary masked", 16'h0000, {15'h0000, summary});
		wr(AOSR_WR_ALM_ENA, 16'h0040);
		chk("summary open", 16'h0001, {15'h0000, summary});
		wr(AOSR_WR_OPR_ENA, 16'h1234);
		wr(AOSR_WR_QUE_ENA, 16'h4321);
		rd(AOSR_RD_OPR_ENA, "oper enable", 16'h1234);
		rd(AOSR_RD_QUE_ENA, "ques enable", 16'h4321);
		wr(AOSR_PRESET, 16'h0000);
		rd(AOSR_RD_ALM_ENA, "alarm enable preset", 16'h0000);
		rd(AOSR_RD_OPR_ENA, "oper enable preset", 16'h0000);
		rd(AOSR_RD_QUE_ENA, "ques enable preset", 16'h0000);
		chk("summary after preset", 16'h0000, {15'h0000, summary});
		alarm = '0;
	endtask

	task automatic t_oper();
		oper = '1;
		ticks(2);
		rd(AOSR_RD_OPR_COND, "oper all", 16'h64B3);
		rd(AOSR_RD_OPR_COND, "oper all again", 16'h64B3);
		wr(AOSR_FACTORY_RST, 16'h0000);
		rd(AOSR_RD_OPR_COND, "oper config changed", 16'h65B3);
		cfg_ack = 1'b1;
		@(negedge clk_in);
		cfg_ack = 1'b0;
		oper = '{busy: 1'b1, default: 1'b0};
		ticks(2);
		rd(AOSR_RD_OPR_COND, "oper busy only", 16'h4000);
		cfg_chg = 1'b1;
		@(negedge clk_in);
		cfg_chg = 1'b0;
		ticks(1);
		rd(AOSR_RD_OPR_COND, "oper config pulse", 16'h4100);
		oper = '0;
		i_aosr_host_model.xfer(aosr_op_t'(4'hD), 16'h0000, val);
		chk("undefined code error", 16'h0001, {15'h0000, rsp.err});
	endtask

	// ==========================================================
	// Clock, reset, sequence and watchdog
	// ==========================================================
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	initial begin
		n_mismatch = 0;
		compares = 0;
		sys_rst_in = 1'b1;
		alarm = '0;
		push = 1'b0;
		pop = 1'b0;
		oper = '0;
		cfg_chg = 1'b0;
		cfg_ack = 1'b0;
		ticks(4);
		sys_rst_in = 1'b0;
		t_alarm_bits();
		t_queue();
		t_enable();
		t_oper();
		wrap_up();
	end

	initial begin
		#100000;
		n_mismatch++;
		wrap_up();
	end
endmodule
